/* File: spist_engine_model.sv */
// Behavioural serial engine feeding queue levels, activity and raw events
`timescale 1ns/1ps
`default_nettype none
module spist_engine_model #(parameter int LVL_W = 4) (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       slow,
  input  wire logic [LVL_W-1:0]           rx_tgt,
  input  wire logic [LVL_W-1:0]           tx_tgt,
  input  wire logic                       busy_tgt,
  input  wire logic [spist_pkg::EV_W-1:0] raw_tgt,
  output logic      [LVL_W-1:0]           rx_level,
  output logic      [LVL_W-1:0]           tx_level,
  output logic                            busy,
  output logic      [spist_pkg::EV_W-1:0] raw_events
);
  logic [1:0] wait_r;
  // Slow mode takes a new state only on every fourth cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_r     <= 2'h0;
      rx_level   <= '0;
      tx_level   <= '0;
      busy       <= 1'b0;
      raw_events <= '0;
    end else if (!slow || wait_r == 2'h3) begin
      wait_r     <= 2'h0;
      rx_level   <= rx_tgt;
      tx_level   <= tx_tgt;
      busy       <= busy_tgt;
      raw_events <= raw_tgt;
    end else begin
      wait_r <= wait_r + 2'h1;
    end
  end
endmodule // spist_engine_model
`default_nettype wire

/* File: spist_flag_if.sv */
// Carrier between the register slave and the flag decoder
`timescale 1ns/1ps
`default_nettype none
interface spist_flag_if #(parameter int LVL_W = 4);
  logic [LVL_W-1:0]             rx_level;
  logic [LVL_W-1:0]             tx_level;
  logic                         busy;
  logic [spist_pkg::EV_W-1:0]   raw_in;
  logic [spist_pkg::STAT_W-1:0] stat;
  logic [spist_pkg::EV_W-1:0]   raw;
  modport dec (input rx_level, input tx_level, input busy, input raw_in, output stat, output raw);
  modport use_side (output rx_level, output tx_level, output busy, output raw_in, input stat, input raw);
endinterface
`default_nettype wire

/* File: spist_flags.sv */
// Combinational decode of queue levels into status flags, with busy and raw events passed through
`timescale 1ns/1ps
`default_nettype none
module spist_flags #(
  parameter int LVL_W = 4,
  parameter int DEPTH = 8
) (
  spist_flag_if.dec fl
);
  // ----------------------------------------------------------------
  // Occupancy and activity flags
  // ----------------------------------------------------------------
  localparam logic [LVL_W-1:0] DEPTH_L = LVL_W'(DEPTH);
  localparam logic [LVL_W-1:0] ZERO_L  = '0;
  assign fl.stat[spist_pkg::STAT_RX_FULL]  = (fl.rx_level == DEPTH_L);
  assign fl.stat[spist_pkg::STAT_RX_DATA]  = (fl.rx_level != ZERO_L);
  assign fl.stat[spist_pkg::STAT_TX_EMPTY] = (fl.tx_level == ZERO_L);
  assign fl.stat[spist_pkg::STAT_TX_ROOM]  = (fl.tx_level < DEPTH_L);
  assign fl.stat[spist_pkg::STAT_BUSY]     = fl.busy;
  // ----------------------------------------------------------------
  // Raw events pass unmasked
  // ----------------------------------------------------------------
  assign fl.raw = fl.raw_in;
endmodule // spist_flags
`default_nettype wire

/* File: spist_pkg.sv */
// Constants for the serial port status flags and interrupt enable mask
`default_nettype none
package spist_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_STATUS = 8'h28;
  localparam logic [7:0] OFF_MASK   = 8'h2c;
  localparam logic [7:0] OFF_MIS    = 8'h30;
  localparam logic [7:0] OFF_RAW    = 8'h34;
  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int STAT_RX_FULL  = 4;
  localparam int STAT_RX_DATA  = 3;
  localparam int STAT_TX_EMPTY = 2;
  localparam int STAT_TX_ROOM  = 1;
  localparam int STAT_BUSY     = 0;
  localparam int STAT_W        = 5;
  localparam int EV_CONTENTION = 5;
  localparam int EV_RX_FULL    = 4;
  localparam int EV_RX_OVER    = 3;
  localparam int EV_RX_UNDER   = 2;
  localparam int EV_TX_OVER    = 1;
  localparam int EV_TX_EMPTY   = 0;
  localparam int EV_W          = 6;
  // ----------------------------------------------------------------
  // Reset values and the NONSEQ transfer code
  // ----------------------------------------------------------------
  localparam logic [EV_W-1:0] MASK_RST = 6'h3f;
  localparam logic [31:0]     RD_ZERO  = 32'h0000_0000;
  localparam logic [1:0]      HTRANS_NONSEQ = 2'h2;
endpackage
`default_nettype wire

/* File: spist_top.sv */
// Status flags and interrupt enable mask with an AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module spist_top #(
  parameter int LVL_W = 4,
  parameter int DEPTH = 8
) (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic      [31:0]                hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  input  wire logic [LVL_W-1:0]           rx_level,
  input  wire logic [LVL_W-1:0]           tx_level,
  input  wire logic                       busy,
  input  wire logic [spist_pkg::EV_W-1:0] raw_events,
  output logic                            irq
);
  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (DEPTH < 1 || DEPTH >= (1 << LVL_W)) begin : g_bad_depth
    $error("DEPTH must fit in LVL_W bits");
  end

  // ----------------------------------------------------------------
  // Flag decoder
  // ----------------------------------------------------------------
  spist_flag_if #(.LVL_W(LVL_W)) fl ();
  assign fl.rx_level = rx_level;
  assign fl.tx_level = tx_level;
  assign fl.busy     = busy;
  assign fl.raw_in   = raw_events;

  spist_flags #(.LVL_W(LVL_W), .DEPTH(DEPTH)) u_flags (
    .fl (fl)
  );

  function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
    hit = (a[31:8] == 24'h00_0000) && (a[7:0] == off);
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [spist_pkg::EV_W-1:0] mask_r;
  logic [spist_pkg::EV_W-1:0] mask_nxt;
  logic                       wr_mask_r;
  logic [31:0]                hrdata_r;
  logic [31:0]                hrdata_nxt;
  logic                       irq_r;

  // ----------------------------------------------------------------
  // Address phase decode
  // ----------------------------------------------------------------
  wire logic                       take     = hsel && hready && (htrans == spist_pkg::HTRANS_NONSEQ);
  wire logic                       take_rd  = take && !hwrite;
  wire logic                       take_wr  = take && hwrite;
  wire logic [spist_pkg::EV_W-1:0] masked   = fl.raw & mask_r;
  wire logic [31:0]                rd_stat  = {27'h000_0000, fl.stat};
  wire logic [31:0]                rd_mask  = {26'h000_0000, mask_r};
  wire logic [31:0]                rd_mis   = {26'h000_0000, masked};
  wire logic [31:0]                rd_raw   = {26'h000_0000, fl.raw};

  always_comb begin
    if (!take_rd) begin
      hrdata_nxt = hrdata_r;
    end else if (hit(haddr, spist_pkg::OFF_STATUS)) begin
      hrdata_nxt = rd_stat;
    end else if (hit(haddr, spist_pkg::OFF_MASK)) begin
      hrdata_nxt = rd_mask;
    end else if (hit(haddr, spist_pkg::OFF_MIS)) begin
      hrdata_nxt = rd_mis;
    end else if (hit(haddr, spist_pkg::OFF_RAW)) begin
      hrdata_nxt = rd_raw;
    end else begin
      hrdata_nxt = spist_pkg::RD_ZERO;
    end
  end

  // Data phase write, only the six enable bits are stored
  assign mask_nxt = wr_mask_r ? hwdata[spist_pkg::EV_W-1:0] : mask_r;

  // ----------------------------------------------------------------
  // Clocked state
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_mask_r <= 1'b0;
    end else begin
      wr_mask_r <= take_wr && hit(haddr, spist_pkg::OFF_MASK);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_r <= spist_pkg::MASK_RST;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= spist_pkg::RD_ZERO;
    end else begin
      hrdata_r <= hrdata_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |masked;
    end
  end

  assign hrdata    = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign irq       = irq_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  localparam logic [LVL_W-1:0] DEPTH_L = LVL_W'(DEPTH);
  wire logic rd_st = take_rd && hit(haddr, spist_pkg::OFF_STATUS);
  wire logic rd_mk = take_rd && hit(haddr, spist_pkg::OFF_MASK);
  wire logic rd_rw = take_rd && hit(haddr, spist_pkg::OFF_RAW);
  wire logic rd_ms = take_rd && hit(haddr, spist_pkg::OFF_MIS);

  AST_RX_FLAGS: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_st |=> (hrdata_r[4] == ($past(rx_level) == DEPTH_L)) && (hrdata_r[3] == ($past(rx_level) != '0)))
    else $error("Rx flags wrong");
  AST_TX_FLAGS: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_st |=> (hrdata_r[2] == ($past(tx_level) == '0)) && (hrdata_r[1] == ($past(tx_level) < DEPTH_L)))
    else $error("Tx flags wrong");
  AST_BUSY_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_st |=> hrdata_r[0] == $past(busy))
    else $error("Busy flag wrong");
  AST_MASK_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
    (take_wr && hit(haddr, spist_pkg::OFF_MASK)) ##1 1'b1 |=> mask_r == $past(hwdata[5:0]))
    else $error("Mask write lost");
  AST_MASK_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_mask_r |=> $stable(mask_r))
    else $error("Mask changed without write");
  AST_MASK_READ: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_mk && !wr_mask_r |=> hrdata_r[5:0] == $past(mask_r))
    else $error("Mask readback wrong");
  AST_MASK_RSVD: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_mk |=> hrdata_r[31:6] == 26'h000_0000)
    else $error("Reserved mask bits nonzero");
  AST_RAW_READ: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_rw |=> hrdata_r[5:0] == $past(raw_events))
    else $error("Raw events wrong");
  AST_IRQ_OR: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> irq == |($past(raw_events) & $past(mask_r)))
    else $error("Irq mismatch");
  AST_IRQ_BLOCK: assert property (@(posedge hclk) disable iff (!hresetn)
    (mask_r == 6'h00) |=> !irq)
    else $error("Irq with all disabled");

  AST_MIS_READ: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_ms |=> hrdata_r[5:0] == ($past(raw_events) & $past(mask_r)))
    else $error("Masked status wrong");

  AST_STAT_RSVD: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_st |=> hrdata_r[31:5] == 27'h000_0000)
    else $error("Status upper bits nonzero");

  AST_RAW_RSVD: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_rw |=> hrdata_r[31:6] == 26'h000_0000)
    else $error("Raw upper bits nonzero");

  AST_PASS_CONT: assert property (@(posedge hclk) disable iff (!hresetn)
    raw_events[spist_pkg::EV_CONTENTION] && mask_r[spist_pkg::EV_CONTENTION] |=> irq)
    else $error("Contention event not passed");

  AST_PASS_RXFULL: assert property (@(posedge hclk) disable iff (!hresetn)
    raw_events[spist_pkg::EV_RX_FULL] && mask_r[spist_pkg::EV_RX_FULL] |=> irq)
    else $error("Rx full event not passed");

  AST_PASS_RXOVER: assert property (@(posedge hclk) disable iff (!hresetn)
    raw_events[spist_pkg::EV_RX_OVER] && mask_r[spist_pkg::EV_RX_OVER] |=> irq)
    else $error("Rx overflow event not passed");

  AST_PASS_RXUNDER: assert property (@(posedge hclk) disable iff (!hresetn)
    raw_events[spist_pkg::EV_RX_UNDER] && mask_r[spist_pkg::EV_RX_UNDER] |=> irq)
    else $error("Rx underflow event not passed");

  AST_PASS_TXOVER: assert property (@(posedge hclk) disable iff (!hresetn)
    raw_events[spist_pkg::EV_TX_OVER] && mask_r[spist_pkg::EV_TX_OVER] |=> irq)
    else $error("Tx overflow event not passed");

  AST_PASS_TXEMPTY: assert property (@(posedge hclk) disable iff (!hresetn)
    raw_events[spist_pkg::EV_TX_EMPTY] && mask_r[spist_pkg::EV_TX_EMPTY] |=> irq)
    else $error("Tx empty event not passed");
endmodule // spist_top
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the status flags and interrupt enable mask
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int DEPTH_TB = 8;
  logic        hclk, hresetn, hsel, hwrite, busy, irq, slow, bsy_t, hrdy, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, seed;
  logic [1:0]  htrans;
  logic [3:0]  rx, tx, rx_t, tx_t;
  logic [5:0]  ev, ev_t, msk;
  int          err_count, n_checks, i;
  spist_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
    .hreadyout(hrdy), .hresp(hresp), .rx_level(rx), .tx_level(tx), .busy(busy), .raw_events(ev), .irq(irq));
  spist_engine_model ENG (.hclk(hclk), .hresetn(hresetn), .slow(slow), .rx_tgt(rx_t), .tx_tgt(tx_t),
    .busy_tgt(bsy_t), .raw_tgt(ev_t), .rx_level(rx), .tx_level(tx), .busy(busy), .raw_events(ev));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hrdy !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hrdy !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  initial begin
    repeat (8000) @(posedge hclk);
    err_count++;
    wrap_up();
  end
  initial begin
    {hresetn, hsel, hwrite, slow, bsy_t} = '0;
    {haddr, hwdata, htrans, rx_t, tx_t, ev_t} = '0;
    seed = 32'hbe2f_ff95;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(32'h2c, 1'b0, 32'h0);
    chk(rd, 32'h3f);
    xfer(32'h28, 1'b1, 32'hffff_ffff);
    xfer(32'h28, 1'b0, 32'h0);
    chk(rd, 32'h6);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    msk = 6'h3f;
    for (i = 0; i < 48; i++) begin
      seed = lfsr(seed);
      rx_t <= 4'(seed[7:0] % 9);
      tx_t <= 4'(seed[15:8] % 9);
      bsy_t <= seed[16];
      ev_t <= seed[22:17];
      slow <= seed[23];
      xfer(32'h2c, 1'b1, seed);
      msk = seed[5:0];
      repeat (6) @(posedge hclk);
      chk({31'h0, irq}, {31'h0, |(ev_t & msk)});
      xfer(32'h28, 1'b0, 32'h0);
      chk(rd, {27'h0, rx_t == DEPTH_TB, rx_t != 0, tx_t == 0, tx_t < DEPTH_TB, bsy_t});
      xfer(32'h2c, 1'b0, 32'h0);
      chk(rd, {26'h0, msk});
      xfer(32'h34, 1'b0, 32'h0);
      chk(rd, {26'h0, ev_t});
      xfer(32'h30, 1'b0, 32'h0);
      chk(rd, {26'h0, ev_t & msk});
      xfer(32'h38 + {seed[27:24], 2'h0}, 1'b0, 32'h0);
      chk(rd, 32'h0);
    end
    // Unselected write must leave the mask alone
    @(posedge hclk);
    hsel <= 1'b0;
    haddr <= 32'h2c;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= {26'h0, ~msk};
    @(posedge hclk);
    xfer(32'h2c, 1'b0, 32'h0);
    chk(rd, {26'h0, msk});
    // Mid-run reset restores the enable mask
    xfer(32'h2c, 1'b1, 32'h0);
    rx_t <= 4'h0;
    tx_t <= 4'h0;
    bsy_t <= 1'b0;
    ev_t <= 6'h00;
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    hresetn <= 1'b1;
    xfer(32'h2c, 1'b0, 32'h0);
    chk(rd, 32'h3f);
    xfer(32'h28, 1'b0, 32'h0);
    chk(rd, 32'h6);
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
